// ---- sba_pkg.sv ----
// Overview of operation
// [R1] Strap low: internal arbiter, requests/grants [7:0] port 1, [6:0] port 2.
// [R2] Two-level rotation per port; low group is one slot in the high ring.
// [R3] Register 40h holds one priority bit per master; 1 high, 0 low.
// [R4] All masters in one group gives plain rotating priority.
// [R5] Reset puts external masters low and the bridge high.
// [R6] Priorities re-evaluated at each frame start; highest asserted request granted.
// [R7] Higher-priority request moves the grant on the next clock.
// [R8] Master that started the last transaction drops to lowest in its group.
// [R9] Grant withdrawn after 16 idle granted cycles; held off until request drops.
// [R10] Idle bus: one dead clock between grants; busy bus may switch directly.
// [R11] Bit 31 of 4Ch disables preemption; zero (enabled) after reset.
// [R12] Time-to-preempt is 8, 16, 32, 64 or 128 clocks, 32 after reset.
// [R13] Busy owner loses grant once a waiter has waited time-to-preempt.
// [R14] Strap high: grant pin 0 is bridge request, request pin 0 its grant.
// [R15] External mode: bridge starts one cycle after its grant seen low.
// [R16] External mode: unused grants [7:1] and [6:1] driven high.
// [R17] Parking drives address and command lines first, parity one cycle later.
// [R18] Primary parked only with grant, no request, idle bus; float after grant.
// [R19] Parked primary may start next clock if primary grant still asserted.
// [R20] Internal arbiter leaves grant with last master until a new request.
// [R21] After reset each secondary bus is parked at the bridge.
// [R22] External mode parks only with grant in, no own request, idle bus.
// [R23] Each port has its own arbiter state, sharing the programming registers.
package sba_pkg;
  localparam logic [7:0] PRIO_OFFSET = 8'h40;
  localparam logic [7:0] PREEMPT_OFFSET = 8'h4C;
  localparam int PREEMPT_OFF_BIT = 31;
  localparam int TSEL_MSB = 30;
  localparam int TSEL_LSB = 28;
  localparam logic [3:0] BRIDGE_IDX = 4'h8;
  localparam logic [3:0] LOW_SLOT = 4'h9;
  localparam logic [8:0] PRIO_RESET = 9'h100;
  localparam logic PREEMPT_OFF_RESET = 1'b0;
  localparam logic [2:0] TSEL_RESET = 3'h2;
  localparam logic [2:0] TSEL_MAX = 3'h4;
  localparam logic [7:0] PREEMPT_BASE = 8'h08;
  localparam logic [4:0] IDLE_LIMIT = 5'h10;

  typedef struct packed {
    logic gnt_on;
    logic [3:0] gnt_idx;
    logic gap;
    logic [3:0] hi_ptr;
    logic [3:0] lo_ptr;
    logic [4:0] idle_cnt;
    logic [7:0] wait_cnt;
    logic [8:0] lockout;
    logic frame_q;
    logic [7:0] gnt_n;
    logic go;
    logic park_ad;
    logic park_par;
  } sba_port_t;

  typedef struct packed {
    sba_port_t [1:0] port;
    logic [8:0] prio;
    logic pre_off;
    logic [2:0] tsel;
    logic strap_meta;
    logic strap;
    logic rvalid;
    logic [31:0] rdata;
    logic up_park;
    logic up_par;
    logic up_go;
  } sba_state_t;
endpackage

// ---- sba_pick.sv ----
`timescale 1ns/1ps
module sba_pick
(
  input wire logic [8:0] req,
  input wire logic [8:0] prio,
  input wire logic [3:0] hi_ptr,
  input wire logic [3:0] lo_ptr,
  output logic win_valid,
  output logic [3:0] win_idx
);
  import sba_pkg::*;

  logic [8:0] lo_req;
  logic lo_found;
  logic [3:0] lo_win;
  logic [4:0] pos;

  // Low ring of 9, then high ring of 10 with slot 9 standing for the low group
  always_comb
  begin
    lo_req = req & ~prio;
    lo_found = 1'b0;
    lo_win = 4'h0;
    win_valid = 1'b0;
    win_idx = BRIDGE_IDX;
    pos = 5'h00;
    for (int n = 0; n < 9; n++)
    begin
      pos = {1'b0, lo_ptr} + 5'(n);
      if (pos >= 5'h09)
        pos = pos - 5'h09;
      if (!lo_found && lo_req[pos[3:0]]) // R2
      begin
        lo_found = 1'b1;
        lo_win = pos[3:0];
      end
    end
    // Empty group drops out, leaving one plain rotation
    for (int n = 0; n < 10; n++) // R4
    begin
      pos = {1'b0, hi_ptr} + 5'(n);
      if (pos >= 5'h0A)
        pos = pos - 5'h0A;
      if (!win_valid)
      begin
        if (pos[3:0] == LOW_SLOT)
        begin
          if (lo_found) // R2
          begin
            win_valid = 1'b1;
            win_idx = lo_win;
          end
        end
        else if (req[pos[3:0]] && prio[pos[3:0]])
        begin
          win_valid = 1'b1;
          win_idx = pos[3:0];
        end
      end
    end
  end
endmodule

// ---- sba_top.sv ----
`timescale 1ns/1ps
module sba_top
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic central_function_strap_n,
  input wire logic [7:0] port1_master_request_n,
  input wire logic [6:0] port2_master_request_n,
  output logic [7:0] port1_master_grant_n,
  output logic [6:0] port2_master_grant_n,
  input wire logic port1_frame_n,
  input wire logic port2_frame_n,
  input wire logic port1_initiator_ready_n,
  input wire logic port2_initiator_ready_n,
  input wire logic port1_bridge_request,
  input wire logic port2_bridge_request,
  output logic port1_bridge_go,
  output logic port2_bridge_go,
  output logic port1_park_ad_oe,
  output logic port1_park_par_oe,
  output logic port2_park_ad_oe,
  output logic port2_park_par_oe,
  input wire logic upstream_grant_n,
  input wire logic upstream_request_n,
  input wire logic upstream_frame_n,
  input wire logic upstream_initiator_ready_n,
  output logic upstream_ad_oe,
  output logic upstream_cmd_byte_en_oe,
  output logic upstream_parity_oe,
  output logic upstream_start_ok,
  input wire logic cfg_write,
  input wire logic cfg_read,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_byte_en,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_rvalid,
  output logic [31:0] cfg_rdata
);
  import sba_pkg::*;

  sba_state_t s_ff;
  sba_state_t nxt_s;
  logic [1:0][8:0] req_raw;
  logic [1:0][8:0] req_elig;
  logic [1:0] frame_n;
  logic [1:0] busy;
  logic [1:0] breq;
  logic [1:0] ext_gnt_n;
  logic [1:0] win_v;
  logic [1:0][3:0] win_i;
  logic [2:0] tsel_eff;
  logic [7:0] lim;

  // Bus pins are synchronous to this clock, so they are used unsynchronised
  assign req_raw[0] = {port1_bridge_request, ~port1_master_request_n}; // R1
  assign req_raw[1] = {port2_bridge_request, 1'b0, ~port2_master_request_n}; // R1
  assign frame_n = {port2_frame_n, port1_frame_n};
  assign busy = ~frame_n | ~{port2_initiator_ready_n, port1_initiator_ready_n};
  assign breq = {port2_bridge_request, port1_bridge_request};
  assign ext_gnt_n = {port2_master_request_n[0], port1_master_request_n[0]}; // R14

  // Out-of-range selects fall back to the longest time
  assign tsel_eff = (s_ff.tsel > TSEL_MAX) ? TSEL_MAX : s_ff.tsel;
  assign lim = PREEMPT_BASE << tsel_eff; // R12

  // One picker per port; rotation state stays per port
  for (genvar p = 0; p < 2; p++) // R23
  begin : g_port
    assign req_elig[p] = req_raw[p] & ~s_ff.port[p].lockout; // R9
    sba_pick u_pick
    (
      .req(req_elig[p]),
      .prio(s_ff.prio),
      .hi_ptr(s_ff.port[p].hi_ptr),
      .lo_ptr(s_ff.port[p].lo_ptr),
      .win_valid(win_v[p]),
      .win_idx(win_i[p])
    );
  end

  // Next-state logic for registers, both ports and primary parking
  always_comb
  begin
    logic bsy;
    logic fstart;
    logic want;
    logic [3:0] own;
    logic [8:0] gn;
    bsy = 1'b0;
    fstart = 1'b0;
    want = 1'b0;
    own = 4'h0;
    gn = 9'h1FF;
    nxt_s = s_ff;
    nxt_s.strap_meta = central_function_strap_n;
    nxt_s.strap = s_ff.strap_meta;
    // Configuration writes honour byte enables
    if (cfg_write && cfg_addr == PRIO_OFFSET)
    begin
      if (cfg_byte_en[0])
        nxt_s.prio[7:0] = cfg_wdata[7:0]; // R3
      if (cfg_byte_en[1])
        nxt_s.prio[8] = cfg_wdata[8]; // R3
    end
    if (cfg_write && cfg_addr == PREEMPT_OFFSET && cfg_byte_en[3])
    begin
      nxt_s.pre_off = cfg_wdata[PREEMPT_OFF_BIT]; // R11
      nxt_s.tsel = cfg_wdata[TSEL_MSB:TSEL_LSB]; // R12
    end
    nxt_s.rvalid = cfg_read;
    nxt_s.rdata = 32'h0000_0000;
    if (cfg_read)
    begin
      case (cfg_addr)
        PRIO_OFFSET: nxt_s.rdata = {23'h000000, s_ff.prio};
        PREEMPT_OFFSET: nxt_s.rdata = {s_ff.pre_off, s_ff.tsel, 15'h0000,
          s_ff.port[1].gnt_on, s_ff.port[1].gnt_idx, 3'h0,
          s_ff.port[0].gnt_on, s_ff.port[0].gnt_idx};
        default: nxt_s.rdata = 32'h0000_0000;
      endcase
    end
    // Both ports share the registers but keep separate state
    for (int p = 0; p < 2; p++) // R23
    begin
      bsy = busy[p];
      fstart = s_ff.port[p].frame_q & ~frame_n[p];
      want = win_v[p] && (!s_ff.port[p].gnt_on || win_i[p] != s_ff.port[p].gnt_idx);
      nxt_s.port[p].frame_q = frame_n[p];
      // Hold-off ends once the request is seen released
      nxt_s.port[p].lockout = s_ff.port[p].lockout & req_raw[p]; // R9
      if (s_ff.strap)
      begin
        // Internal arbiter idle; pin 0 pair talks to the outside arbiter
        nxt_s.port[p].gnt_on = 1'b0; // R14
        nxt_s.port[p].gnt_idx = BRIDGE_IDX;
        nxt_s.port[p].gap = 1'b0;
        nxt_s.port[p].idle_cnt = 5'h00;
        nxt_s.port[p].wait_cnt = 8'h00;
        nxt_s.port[p].go = breq[p] & ~s_ff.port[p].gnt_n[0] & ~ext_gnt_n[p]; // R15
        nxt_s.port[p].park_ad = ~ext_gnt_n[p] & ~breq[p] & ~bsy; // R22
        gn = {8'hFF, ~breq[p]}; // R14 R16
      end
      else
      begin
        // Starter of the transaction goes to the back of its group
        if (fstart && s_ff.port[p].gnt_on) // R6
        begin
          own = s_ff.port[p].gnt_idx;
          if (s_ff.prio[own])
            nxt_s.port[p].hi_ptr = own + 4'h1; // R8
          else
          begin
            nxt_s.port[p].lo_ptr = (own == BRIDGE_IDX) ? 4'h0 : own + 4'h1; // R8
            nxt_s.port[p].hi_ptr = 4'h0; // R8
          end
        end
        // Count idle cycles while a requester holds the grant unused
        if (s_ff.port[p].gnt_on && req_raw[p][s_ff.port[p].gnt_idx] && !bsy)
          nxt_s.port[p].idle_cnt = s_ff.port[p].idle_cnt + 5'h01; // R9
        else
          nxt_s.port[p].idle_cnt = 5'h00;
        if (nxt_s.port[p].idle_cnt == IDLE_LIMIT)
        begin
          nxt_s.port[p].gnt_on = 1'b0; // R9
          nxt_s.port[p].gap = 1'b1;
          nxt_s.port[p].idle_cnt = 5'h00;
          nxt_s.port[p].lockout[s_ff.port[p].gnt_idx] = 1'b1; // R9
        end
        else if (s_ff.port[p].gap)
        begin
          // Dead clock over; with no requester the bus parks at the bridge
          nxt_s.port[p].gap = 1'b0;
          nxt_s.port[p].gnt_on = 1'b1; // R10
          nxt_s.port[p].gnt_idx = win_v[p] ? win_i[p] : BRIDGE_IDX;
        end
        else if (want && bsy && s_ff.port[p].gnt_on)
        begin
          // Busy bus: switch only after the waiter's time-to-preempt
          if (!s_ff.pre_off && s_ff.port[p].wait_cnt >= lim - 8'h01) // R11 R13
          begin
            nxt_s.port[p].gnt_idx = win_i[p]; // R10 R13
            nxt_s.port[p].wait_cnt = 8'h00;
          end
          else if (s_ff.port[p].wait_cnt != 8'hFF)
            nxt_s.port[p].wait_cnt = s_ff.port[p].wait_cnt + 8'h01;
        end
        else if (want && s_ff.port[p].gnt_on)
        begin
          nxt_s.port[p].gnt_on = 1'b0; // R7 R10
          nxt_s.port[p].gap = 1'b1;
          nxt_s.port[p].wait_cnt = 8'h00;
        end
        else if (want)
        begin
          nxt_s.port[p].gnt_on = 1'b1; // R6
          nxt_s.port[p].gnt_idx = win_i[p];
        end
        else
          nxt_s.port[p].wait_cnt = 8'h00; // R20
        nxt_s.port[p].go = s_ff.port[p].gnt_on && s_ff.port[p].gnt_idx == BRIDGE_IDX
          && breq[p];
        nxt_s.port[p].park_ad = s_ff.port[p].gnt_on && !breq[p] && !bsy
          && s_ff.port[p].gnt_idx == BRIDGE_IDX; // R21
        for (int i = 0; i < 9; i++)
          gn[i] = !(nxt_s.port[p].gnt_on && nxt_s.port[p].gnt_idx == 4'(i));
      end
      nxt_s.port[p].gnt_n = gn[7:0];
      nxt_s.port[p].park_par = nxt_s.port[p].park_ad & s_ff.port[p].park_ad; // R17
    end
    // Primary parking follows the sampled primary grant
    nxt_s.up_park = ~upstream_grant_n & upstream_request_n & upstream_frame_n
      & upstream_initiator_ready_n; // R18
    nxt_s.up_par = nxt_s.up_park & s_ff.up_park; // R17
    nxt_s.up_go = s_ff.up_park & ~upstream_grant_n; // R19
  end

  // State register; bridge owns both secondary buses out of reset
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      s_ff <= '0;
      s_ff.prio <= PRIO_RESET; // R5
      s_ff.pre_off <= PREEMPT_OFF_RESET; // R11
      s_ff.tsel <= TSEL_RESET; // R12
      for (int p = 0; p < 2; p++)
      begin
        s_ff.port[p].gnt_on <= 1'b1; // R21
        s_ff.port[p].gnt_idx <= BRIDGE_IDX; // R21
        s_ff.port[p].gnt_n <= 8'hFF;
        s_ff.port[p].frame_q <= 1'b1;
      end
    end
    else
      s_ff <= nxt_s;
  end

  // Outputs straight from the state register
  assign port1_master_grant_n = s_ff.port[0].gnt_n;
  assign port2_master_grant_n = s_ff.port[1].gnt_n[6:0];
  assign port1_bridge_go = s_ff.port[0].go;
  assign port2_bridge_go = s_ff.port[1].go;
  assign port1_park_ad_oe = s_ff.port[0].park_ad;
  assign port1_park_par_oe = s_ff.port[0].park_par;
  assign port2_park_ad_oe = s_ff.port[1].park_ad;
  assign port2_park_par_oe = s_ff.port[1].park_par;
  assign upstream_ad_oe = s_ff.up_park;
  assign upstream_cmd_byte_en_oe = s_ff.up_park;
  assign upstream_parity_oe = s_ff.up_par;
  assign upstream_start_ok = s_ff.up_go;
  assign cfg_rvalid = s_ff.rvalid;
  assign cfg_rdata = s_ff.rdata;

  sequence idle_held;
    !s_ff.strap && !busy[0] && !(&port1_master_grant_n);
  endsequence

  sequence park_start;
    $rose(port1_park_ad_oe);
  endsequence

  a_ext_unused_high: assert property (@(posedge clock) disable iff (!reset_n) // R16
    s_ff.strap |=> (&port1_master_grant_n[7:1]) && (&port2_master_grant_n[6:1]))
    else $error("unused grants not high in external mode");

  a_idle_no_swap: assert property (@(posedge clock) disable iff (!reset_n) // R10
    idle_held ##1 !(&port1_master_grant_n) |-> $stable(port1_master_grant_n))
    else $error("grant switched without dead clock on idle bus");

  a_timeout_drop: assert property (@(posedge clock) disable iff (!reset_n) // R9
    !s_ff.strap && s_ff.port[0].idle_cnt == IDLE_LIMIT - 5'h01 && s_ff.port[0].gnt_on
    && req_raw[0][s_ff.port[0].gnt_idx] && !busy[0]
    |=> !s_ff.port[0].gnt_on && s_ff.port[0].lockout != 9'h000)
    else $error("idle grant not withdrawn after timeout");

  a_lockout_hold: assert property (@(posedge clock) disable iff (!reset_n) // R9
    !s_ff.strap && (s_ff.port[0].lockout[7:0] & ~port1_master_request_n) != 8'h00
    |=> (~port1_master_grant_n & $past(s_ff.port[0].lockout[7:0])) == 8'h00)
    else $error("locked-out master granted again");

  a_reset_park: assert property (@(posedge clock) // R5 R21
    !reset_n |=> s_ff.prio == PRIO_RESET && s_ff.port[0].gnt_idx == BRIDGE_IDX
    && s_ff.port[1].gnt_on && s_ff.tsel == TSEL_RESET)
    else $error("wrong state after reset");

  a_preempt_switch: assert property (@(posedge clock) disable iff (!reset_n) // R13
    !s_ff.strap && !s_ff.pre_off && busy[0] && s_ff.port[0].gnt_on && win_v[0]
    && win_i[0] != s_ff.port[0].gnt_idx && !s_ff.port[0].gap
    && s_ff.port[0].wait_cnt >= lim - 8'h01
    |=> s_ff.port[0].gnt_idx == $past(win_i[0]))
    else $error("busy owner not preempted on time");

  a_park_par_lag: assert property (@(posedge clock) disable iff (!reset_n) // R17
    park_start |-> !port1_park_par_oe ##1 (port1_park_par_oe || !port1_park_ad_oe))
    else $error("parity park not one cycle after address park");

  a_up_float: assert property (@(posedge clock) disable iff (!reset_n) // R18
    upstream_grant_n |=> !upstream_ad_oe && !upstream_parity_oe)
    else $error("primary lines still parked after grant removed");

  a_ext_start: assert property (@(posedge clock) disable iff (!reset_n) // R15
    s_ff.strap && port1_bridge_request && !port1_master_grant_n[0]
    && !port1_master_request_n[0] |=> port1_bridge_go)
    else $error("bridge did not start after external grant");

  a_rotate_high: assert property (@(posedge clock) disable iff (!reset_n) // R8
    !s_ff.strap && s_ff.port[0].frame_q && !port1_frame_n && s_ff.port[0].gnt_on
    && s_ff.prio[s_ff.port[0].gnt_idx]
    |=> s_ff.port[0].hi_ptr == $past(s_ff.port[0].gnt_idx) + 4'h1)
    else $error("high group rotation not advanced");
endmodule

// ---- sba_master_model.sv ----
`timescale 1ns/1ps
module sba_master_model
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] want,
  input wire logic lazy,
  input wire logic [7:0] burst,
  input wire logic [7:0] grant_n,
  output logic [7:0] req_n,
  output logic frame_n,
  output logic irdy_n,
  output logic start,
  output logic [2:0] start_idx
);
  logic [7:0] left;
  // Level requests; a granted master starts only on an idle bus
  always_ff @(posedge clock)
  begin
    start <= 1'b0;
    if (!reset_n)
    begin
      req_n <= 8'hFF;
      frame_n <= 1'b1;
      irdy_n <= 1'b1;
      left <= 8'h00;
    end
    else
    begin
      req_n <= ~want;
      if (left != 8'h00)
      begin
        // Frame released on the last data phase, irdy one later
        left <= left - 8'h01;
        irdy_n <= 1'b0;
        frame_n <= (left == 8'h01);
      end
      else
      begin
        // Released lines return to their pull-up level
        frame_n <= 1'b1;
        irdy_n <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
          if (!grant_n[i] && !req_n[i] && !lazy && frame_n && irdy_n && !start)
          begin
            frame_n <= 1'b0;
            left <= burst;
            start <= 1'b1;
            start_idx <= i[2:0];
          end
        end
      end
    end
  end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import sba_pkg::*;
  `define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end
  `define WAITFOR(c) begin k = 0; while (!(c) && k < 300) begin @(posedge clock); #1; \
    k++; end if (k >= 300) begin n_errors++; $display("wrong value wait exp 1 got 0"); \
    summarize(); end end
  typedef struct packed {
    logic [7:0] a;
    logic [3:0] b;
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] e;
  } sba_row_t;
  sba_row_t rows [7] = '{
    '{8'h40, 4'hF, 32'h000001FF, 32'h000001FF, 32'h000001FF},
    '{8'h40, 4'h1, 32'h00000000, 32'h000001FF, 32'h00000100},
    '{8'h4C, 4'h7, 32'h80000000, 32'h80000000, 32'h00000000},
    '{8'h4C, 4'h8, 32'h80000000, 32'hF0000000, 32'h80000000},
    '{8'h4C, 4'h8, 32'h20000000, 32'hF0000000, 32'h20000000},
    '{8'h10, 4'hF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00000000},
    '{8'h40, 4'hF, 32'h00000100, 32'h000001FF, 32'h00000100}};
  int n_errors = 0;
  int check_count = 0;
  int k;
  int c1;
  int c2;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic strap_n = 1'b0;
  logic ext_gnt_n = 1'b1;
  logic br1 = 1'b0;
  logic br2 = 1'b0;
  logic up_gnt_n = 1'b1;
  logic up_req_n = 1'b1;
  logic lazy = 1'b0;
  logic cw = 1'b0;
  logic cr = 1'b0;
  logic [7:0] ca = 8'h00;
  logic [3:0] cbe = 4'h0;
  logic [31:0] cwd = 32'h0;
  logic [7:0] want1 = 8'h00;
  logic [7:0] want2 = 8'h00;
  logic [7:0] burst = 8'h03;
  logic [7:0] g1;
  logic [6:0] g2;
  logic [7:0] r1;
  logic [7:0] r2;
  logic f1, i1, f2, i2, st1, st2, go1, go2, pad1, ppar1, pad2, ppar2;
  logic up_ad, up_cbe, up_par, up_ok, crv;
  logic [2:0] si1;
  logic [2:0] si2;
  logic [31:0] crd;
  logic [31:0] rd;
  always #4 clock = ~clock;
  sba_master_model m1_inst (.clock(clock), .reset_n(reset_n), .want(want1), .lazy(lazy),
    .burst(burst), .grant_n(g1), .req_n(r1), .frame_n(f1), .irdy_n(i1), .start(st1),
    .start_idx(si1));
  sba_master_model m2_inst (.clock(clock), .reset_n(reset_n), .want(want2), .lazy(lazy),
    .burst(burst), .grant_n({1'b1, g2}), .req_n(r2), .frame_n(f2), .irdy_n(i2),
    .start(st2), .start_idx(si2));
  sba_top sba_top_inst (.clock(clock), .reset_n(reset_n), .central_function_strap_n(strap_n),
    .port1_master_request_n(strap_n ? {r1[7:1], ext_gnt_n} : r1),
    .port2_master_request_n(r2[6:0]), .port1_master_grant_n(g1), .port2_master_grant_n(g2),
    .port1_frame_n(f1), .port2_frame_n(f2), .port1_initiator_ready_n(i1),
    .port2_initiator_ready_n(i2), .port1_bridge_request(br1), .port2_bridge_request(br2),
    .port1_bridge_go(go1), .port2_bridge_go(go2), .port1_park_ad_oe(pad1),
    .port1_park_par_oe(ppar1), .port2_park_ad_oe(pad2), .port2_park_par_oe(ppar2),
    .upstream_grant_n(up_gnt_n), .upstream_request_n(up_req_n), .upstream_frame_n(1'b1),
    .upstream_initiator_ready_n(1'b1), .upstream_ad_oe(up_ad),
    .upstream_cmd_byte_en_oe(up_cbe), .upstream_parity_oe(up_par),
    .upstream_start_ok(up_ok), .cfg_write(cw), .cfg_read(cr), .cfg_addr(ca),
    .cfg_byte_en(cbe), .cfg_wdata(cwd), .cfg_rvalid(crv), .cfg_rdata(crd));
  // Verdict in one place; timeouts land here too
  task summarize();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task cfg_wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge clock);
    #1;
    {cw, ca, cbe, cwd} = {1'b1, a, b, d};
    @(posedge clock);
    #1;
    cw = 1'b0;
  endtask
  // Read data is taken the cycle after the strobe edge
  task cfg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    #1;
    {cr, ca} = {1'b1, a};
    @(posedge clock);
    #1;
    cr = 1'b0;
    `CHK("rvalid", 1'b1, crv)
    d = crd;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  initial
  begin
    cyc(3);
    reset_n = 1'b1;
    `CHK("grants", 8'hFF, g1)
    cfg_rd(PRIO_OFFSET, rd);
    `CHK("prio", 32'h100, rd)
    cfg_rd(PREEMPT_OFFSET, rd);
    `CHK("preempt", 32'h20000008, rd & 32'hF000000F)
    `CHK("park at bridge", 4'hF, {pad1, ppar1, pad2, ppar2})
    $display("reset test done");
    foreach (rows[j])
    begin
      cfg_wr(rows[j].a, rows[j].b, rows[j].d);
      cfg_rd(rows[j].a, rd);
      `CHK("reg", rows[j].e, rd & rows[j].m)
    end
    $display("register rows done");
    // Two low masters alternate; all-high must rotate the same way
    for (int p = 0; p < 2; p++)
    begin
      cfg_wr(PRIO_OFFSET, 4'hF, p ? 32'h1FF : 32'h100);
      {c1, c2, k} = '0;
      want1 = 8'h06;
      while (c1 + c2 < 4 && k < 300)
      begin
        cyc(1);
        k++;
        c1 += (st1 && si1 == 3'h1);
        c2 += (st1 && si1 == 3'h2);
      end
      `CHK("m1 starts", 2, c1)
      `CHK("m2 starts", 2, c2)
      want1 = 8'h00;
      cyc(6);
      `CHK("parked", 1'b1, g1 != 8'hFF)
    end
    $display("rotation done");
    // Long transfer must lose its grant after the waiter's 32 clocks
    burst = 8'hC8;
    want1 = 8'h02;
    `WAITFOR(st1)
    want1 = 8'h06;
    `WAITFOR(g1[1])
    `CHK("preempt time", 1'b1, k >= 30 && k <= 40)
    want1 = 8'h00;
    burst = 8'h03;
    `WAITFOR(f1 && i1)
    $display("preempt done");
    // Idle grant withdrawn, then held off while request stays
    lazy = 1'b1;
    want1 = 8'h08;
    `WAITFOR(!g1[3])
    `WAITFOR(g1[3])
    `CHK("idle grant", 1'b1, k >= 16 && k <= 17)
    c1 = 0;
    repeat (20)
    begin
      cyc(1);
      c1 += !g1[3];
    end
    `CHK("lockout", 0, c1)
    want1 = 8'h00;
    cyc(2);
    want1 = 8'h08;
    `WAITFOR(!g1[3])
    `CHK("regrant delay", 3, k)
    want1 = 8'h00;
    lazy = 1'b0;
    want2 = 8'h10;
    `WAITFOR(!g2[4])
    `CHK("port1 apart", 8'hF7, g1)
    want2 = 8'h00;
    $display("timeout and port2 done");
    strap_n = 1'b1;
    cyc(4);
    br1 = 1'b1;
    cyc(2);
    `CHK("bridge req", 1'b0, g1[0])
    `CHK("unused1", 7'h7F, g1[7:1])
    `CHK("unused2", 6'h3F, g2[6:1])
    `CHK("port2 idle", 3'h0, {go2, pad2, ppar2})
    ext_gnt_n = 1'b0;
    `WAITFOR(go1)
    `CHK("go delay", 1, k)
    br1 = 1'b0;
    `WAITFOR(pad1)
    `CHK("sec par lag", 1'b0, ppar1)
    cyc(1);
    `CHK("sec par", 1'b1, ppar1)
    ext_gnt_n = 1'b1;
    `WAITFOR(!pad1)
    `CHK("sec float", 1'b1, k <= 2)
    strap_n = 1'b0;
    cyc(4);
    $display("external mode done");
    up_req_n = 1'b0;
    up_gnt_n = 1'b0;
    cyc(3);
    `CHK("no park req", 1'b0, up_ad)
    up_req_n = 1'b1;
    `WAITFOR(up_ad)
    `CHK("up par lag", 1'b0, up_par)
    `CHK("up cbe", 1'b1, up_cbe)
    cyc(1);
    `CHK("up par", 1'b1, up_par)
    `CHK("start ok", 1'b1, up_ok)
    up_gnt_n = 1'b1;
    cyc(1);
    `CHK("start off", 1'b0, up_ok)
    `WAITFOR(!up_ad)
    `CHK("up float", 1'b1, k <= 1)
    $display("primary park done");
    reset_n = 1'b0;
    cyc(2);
    reset_n = 1'b1;
    cfg_rd(PRIO_OFFSET, rd);
    `CHK("prio again", 32'h100, rd)
    $display("second reset done");
    summarize();
  end
endmodule
